/* File: sync2.sv */
// two flip-flop level synchroniser, parameter width
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1 // bits carried
) (
  input  wire logic         i_clk,   // destination clock
  input  wire logic         i_rst_n, // synchronous reset
  input  wire logic [W-1:0] i_d,     // asynchronous level
  output logic      [W-1:0] o_q      // synchronised level
);
  logic [W-1:0] meta_q; // first stage, read only by second
  // two stages in series
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_q <= '0;
      o_q    <= '0;
    end else begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end
endmodule

/* File: tb.sv */
// self-checking bench joining both ends of the port
`timescale 1ns/1ps
module tb;
  logic       clk = 1'b0, rst_n = 1'b0;            // clock, reset
  logic       we = 1'b0, cyc = 1'b0, stb = 1'b0;   // wishbone control
  logic [3:0] adr = 4'h0;                          // wishbone address
  logic [7:0] wdat = 8'h00, rdat, q;               // wishbone data
  logic       ack;                                 // wishbone ack
  logic       i2c = 1'b0, fpp = 1'b0, crc = 1'b0;  // mode straps
  logic       fwd = 1'b0, fmap = 1'b0, edh = 1'b0; // straps, error
  logic       comp = 1'b0, trs = 1'b0, eav = 1'b0, sav = 1'b0; // words
  logic [3:0] std = 4'h0, std_o;                   // standard code
  logic [4:0] ff = 5'h15, ap = 5'h0a, anc = 5'h1c, ovr; // flag sets
  logic       i2c_o, crc_o, fw_o, fmap_o, fclr_n, rwe, ovr_v; // status
  logic [2:0] ridx;                                // register index
  logic [7:0] rwd, seen_idx, seen_dat;             // register writes
  logic [2:0] i2a;                                 // i2c address straps
  logic       scl_o, sda_o;                        // serial lines seen
  logic [1:0] pg;                                  // last flag group seen
  logic [5:0] fc [6] = '{6'h14, 6'h13, 6'h02, 6'h05, 6'h28, 6'h35};
  int         fail_count = 0, num_checks = 0;      // tallies
  vidport_if  vif ();                              // pins between ends
  always #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////
  vidport_dev i_vidport_dev (.i_clk(clk), .i_rst_n(rst_n), .bus(vif.dev),
    .i_fifo_pulse_placement(fpp), .i_crc_check(crc),
    .i_flywheel_disable(fwd), .i_flag_map_en(fmap), .i_composite(comp),
    .i_trs_id_word(trs), .i_eav_word(eav), .i_sav_word(sav),
    .i_std_code(std), .i_ff_flags(ff), .i_ap_flags(ap),
    .i_anc_flags(anc), .i_edh_error(edh), .o_i2c_mode(i2c_o),
    .o_crc_mode(crc_o), .o_flywheel_en(fw_o), .o_flag_map(fmap_o),
    .o_fifo_clear_n(fclr_n), .o_standard_code_out(std_o),
    .o_i2c_addr(i2a), .o_scl(scl_o), .o_sda_in(sda_o), .o_reg_we(rwe),
    .o_reg_idx(ridx), .o_reg_wdata(rwd), .o_flag_override(ovr),
    .o_override_valid(ovr_v));
  vidport_host i_vidport_host (.i_clk(clk), .i_rst_n(rst_n),
    .i_i2c_mode(i2c), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_we(we),
    .i_wb_sel(1'b1), .i_wb_cyc(cyc), .i_wb_stb(stb), .o_wb_dat(rdat),
    .o_wb_ack(ack), .bus(vif.hst));
  vidport_sva i_vidport_sva (.i_clk(clk), .i_rst_n(rst_n),
    .hbus(vif.hbus), .hbus_dev_oe_n(vif.hbus_dev_oe_n),
    .hbus_hst_oe_n(vif.hbus_hst_oe_n), .rd_wr(vif.rd_wr),
    .addr_data(vif.addr_data), .port_sel_n(vif.port_sel_n),
    .host_mode(vif.host_mode), .flag_dev_oe_n(vif.flag_dev_oe_n),
    .flag_dir(vif.flag_dir), .irq_n(vif.irq_n),
    .pclk_out(vif.pclk_out), .i_edh_error(edh));
  // capture each register write seen by the device
  always @(posedge clk) if (rwe === 1'b1) begin
    seen_idx <= {5'h00, ridx};
    seen_dat <= rwd;
  end
  ////////////////////////////////////////////////////////////////////
  // compare one value
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic wishbone cycle, read data left in q
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 40) fail_count++;
  endtask
  // start a host bus cycle and poll busy until it ends
  task automatic hop(input logic [7:0] cmd);
    int n;
    n = 0;
    wb(1'b1, vidport_pkg::A_CMD, cmd);
    do begin
      wb(1'b0, vidport_pkg::A_STATUS, 8'h00);
      n++;
    end while (q[0] !== 1'b0 && n < 20);
    if (n >= 20) fail_count++;
  endtask
  // read one device register through the parallel port
  task automatic rd_reg(input logic [7:0] idx);
    wb(1'b1, vidport_pkg::A_WDATA, idx);
    hop(8'h05);
    hop(8'h03);
    wb(1'b0, vidport_pkg::A_RDATA, 8'h00);
  endtask
  // verdict and end of run
  task automatic end_of_test;
    if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    #750000;
    fail_count++;
    end_of_test();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // straps and standard code, both levels
    for (int v = 0; v < 2; v++) begin
      i2c <= v[0];
      crc <= v[0];
      fwd <= v[0];
      std <= {v[0], 3'h5};
      repeat (8) @(posedge clk);
      chk(i2c_o, v[0]);
      chk(crc_o, v[0]);
      chk(fw_o, !v[0]);
      chk(std_o, {v[0], 3'h5});
      chk({3'h0, i2a, scl_o, sda_o}, 8'h1f);
    end
    i2c <= 1'b0;
    // fifo clear placement table: word inputs, expected level
    foreach (fc[i]) begin
      {comp, fpp, trs, eav, sav} <= fc[i][5:1];
      repeat (3) @(posedge clk);
      chk(fclr_n, fc[i][0]);
    end
    {comp, fpp, trs, eav, sav} <= 5'h00;
    // address then data write, then read back
    wb(1'b1, vidport_pkg::A_WDATA, 8'h06);
    hop(8'h05);
    wb(1'b1, vidport_pkg::A_WDATA, 8'ha7);
    hop(8'h01);
    chk(seen_idx, 8'h06);
    chk(seen_dat, 8'ha7);
    rd_reg(8'h06);
    chk(q, 8'ha7);
    // every flag group read back through the flag port
    for (int g = 0; g < 4; g++) begin
      wb(1'b1, vidport_pkg::A_FLAGC, {5'h00, g[1:0], 1'b1});
      repeat (12) @(posedge clk);
      wb(1'b0, vidport_pkg::A_FLAGS, 8'h00);
      chk(q & 8'h1f, {3'h0, g == 0 ? ff : g == 1 ? ap :
                       g == 2 ? anc : 5'h00});
    end
    // flags driven by the host overwrite the packet flags
    wb(1'b1, vidport_pkg::A_FLAGC, 8'h98);
    repeat (12) @(posedge clk);
    chk({2'h0, ovr_v, ovr}, 8'h33);
    // interrupt raised then released
    for (int e = 1; e >= 0; e--) begin
      edh <= e[0];
      repeat (8) @(posedge clk);
      wb(1'b0, vidport_pkg::A_FLAGS, 8'h00);
      chk(q & 8'h20, {2'h0, !e[0], 5'h00});
    end
    // flag-map mode with flags as outputs
    wb(1'b1, vidport_pkg::A_FLAGC, 8'h01);
    fmap <= 1'b1;
    repeat (8) @(posedge clk);
    chk(fmap_o, 1'b1);
    // group steps ff, ap, anc each clock-out period; flags follow it
    pg = vif.grp;
    repeat (3) begin
      repeat (2) @(posedge clk);
      chk(vif.grp, pg == 2'h2 ? 2'h0 : pg + 2'h1);
      chk(vif.flag, vif.grp == 2'h0 ? ff :
          vif.grp == 2'h1 ? ap : anc);
      pg = vif.grp;
    end
    fmap <= 1'b0;
    // mid-run reset clears the register image
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(8'h06);
    chk(q, vidport_pkg::CFG_RST);
    end_of_test();
  end
endmodule

/* File: vidport_dev.sv */
// device end: host port, flag port, straps and interrupt
//
// Design decisions made here: register access over the parallel host port and the register image.
`timescale 1ns/1ps
module vidport_dev (
  input  wire logic       i_clk,          // core clock
  input  wire logic       i_rst_n,        // synchronous reset, low
  vidport_if.dev          bus,            // pins to host
  input  wire logic       i_fifo_pulse_placement, // high eav, low sav
  input  wire logic       i_crc_check,    // crc mode strap
  input  wire logic       i_flywheel_disable, // flywheel strap
  input  wire logic       i_flag_map_en,  // flag-map mode strap
  input  wire logic       i_composite,    // standard is composite
  input  wire logic       i_trs_id_word,  // trs id word now
  input  wire logic       i_eav_word,     // eav word now
  input  wire logic       i_sav_word,     // sav word now
  input  wire logic [3:0] i_std_code,     // detected standard
  input  wire logic [4:0] i_ff_flags,     // ff flag set
  input  wire logic [4:0] i_ap_flags,     // ap flag set
  input  wire logic [4:0] i_anc_flags,    // anc flag set
  input  wire logic       i_edh_error,    // edh error seen
  output logic            o_i2c_mode,     // host port in i2c mode
  output logic            o_crc_mode,     // crc mode enabled
  output logic            o_flywheel_en,  // flywheel running
  output logic            o_flag_map,     // flag-map mode on
  output logic            o_fifo_clear_n, // downstream fifo clear
  output logic [3:0]      o_standard_code_out, // standard code
  output logic [2:0]      o_i2c_addr,     // i2c slave address straps
  output logic            o_scl,          // synced serial clock
  output logic            o_sda_in,       // synced serial data
  output logic            o_reg_we,       // register write pulse
  output logic [2:0]      o_reg_idx,      // register index
  output logic [7:0]      o_reg_wdata,    // register write data
  output logic [4:0]      o_flag_override,// flags for edh packet
  output logic            o_override_valid // override in use
);
  ////////////////////////////////////////////////////////////////
  // synchronised host pins
  logic [7:0] hb_s;     // host bus after sync
  logic [2:0] ctl_s;    // rd_wr, addr_data, port_sel_n after sync
  logic       mode_s;   // mode strap after sync
  sync2 #(.W(8)) u_sync_hb (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_d     (bus.hbus),
    .o_q     (hb_s)
  );
  sync2 #(.W(4)) u_sync_ctl (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_d     ({bus.host_mode, bus.rd_wr, bus.addr_data,
               bus.port_sel_n}),
    .o_q     ({mode_s, ctl_s})
  );
  logic       rd_s, ad_s, cs_n_s;
  assign rd_s   = ctl_s[2];
  assign ad_s   = ctl_s[1];
  assign cs_n_s = ctl_s[0];
  ////////////////////////////////////////////////////////////////
  // parallel clock out: half rate of core clock
  logic pclk_q;       // parallel clock level
  logic pclk_fall;    // next edge is falling
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) pclk_q <= 1'b0;
    else          pclk_q <= ~pclk_q;
  end
  assign pclk_fall = pclk_q;
  assign bus.pclk_out = pclk_q;
  ////////////////////////////////////////////////////////////////
  // mode and static straps
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_i2c_mode    <= 1'b0;
      o_crc_mode    <= 1'b0;
      o_flywheel_en <= 1'b0;
      o_flag_map    <= 1'b0;
      o_i2c_addr    <= '0;
    end else begin
      o_i2c_mode    <= mode_s;
      o_crc_mode    <= i_crc_check;
      o_flywheel_en <= ~i_flywheel_disable;
      o_flag_map    <= i_flag_map_en;
      o_i2c_addr    <= hb_s[2:0];
    end
  end
  // serial lines taken from the synced bus
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_scl    <= 1'b1;
      o_sda_in <= 1'b1;
    end else begin
      o_scl    <= hb_s[vidport_pkg::SCL_BIT];
      o_sda_in <= hb_s[vidport_pkg::SDA_BIT];
    end
  end
  ////////////////////////////////////////////////////////////////
  // parallel port: address latch, write strobe, read back
  logic [2:0] idx_q;                  // latched register index
  logic [7:0] regs_q [vidport_pkg::REG_NUM]; // register image
  logic       cs_act_q;               // previous select active
  logic       strobe;                 // select fell this cycle
  assign strobe = !o_i2c_mode && !cs_n_s && !cs_act_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) cs_act_q <= 1'b0;
    else          cs_act_q <= !cs_n_s;
  end
  // address or data byte capture
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      idx_q       <= '0;
      o_reg_we    <= 1'b0;
      o_reg_idx   <= '0;
      o_reg_wdata <= '0;
    end else begin
      o_reg_we <= 1'b0;
      if (strobe && ad_s) begin
        idx_q <= hb_s[2:0];
      end else if (strobe && !ad_s && !rd_s) begin
        o_reg_we    <= 1'b1;
        o_reg_idx   <= idx_q;
        o_reg_wdata <= hb_s;
      end
    end
  end
  // register image updated by host writes
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      for (int k = 0; k < vidport_pkg::REG_NUM; k++)
        regs_q[k] <= vidport_pkg::CFG_RST;
    end else if (o_reg_we) begin
      regs_q[o_reg_idx] <= o_reg_wdata;
    end
  end
  // bus drive: only select low, read, data phase, parallel mode
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      bus.hbus_dev_oe_n <= 8'hff;
      bus.hbus_dev_o    <= 8'h00;
    end else begin
      bus.hbus_dev_o    <= regs_q[idx_q];
      if (!o_i2c_mode && !cs_n_s && rd_s && !ad_s)
        bus.hbus_dev_oe_n <= 8'h00;
      else
        bus.hbus_dev_oe_n <= 8'hff;             // float
    end
  end
  ////////////////////////////////////////////////////////////////
  // flag port, sampled on rising clock out, driven on falling
  function automatic logic [4:0] pick(input logic [1:0] g,
                                      input logic [4:0] ff,
                                      input logic [4:0] ap,
                                      input logic [4:0] anc);
    case (g)
      vidport_pkg::GRP_FF:  pick = ff;
      vidport_pkg::GRP_AP:  pick = ap;
      vidport_pkg::GRP_ANC: pick = anc;
      default:              pick = 5'h00;
    endcase
  endfunction
  logic [1:0] grp_q;   // sampled group select
  logic [1:0] map_grp_q; // group stepped in flag-map mode
  logic       dir_q;   // sampled flag direction
  logic [1:0] grp_use;
  assign grp_use = o_flag_map ? map_grp_q : grp_q;
  // input sampling at rising edge of clock out
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      grp_q            <= vidport_pkg::GRP_FF;
      dir_q            <= 1'b1;
      o_flag_override  <= '0;
      o_override_valid <= 1'b0;
    end else if (!pclk_fall) begin
      grp_q            <= bus.grp;
      dir_q            <= bus.flag_dir;
      o_override_valid <= !bus.flag_dir && !o_flag_map;
      if (!bus.flag_dir)
        o_flag_override <= bus.flag;
    end
  end
  // outputs launched at falling edge of clock out
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      bus.flag_dev_o      <= '0;
      bus.flag_dev_oe_n   <= 1'b1;
      bus.grp_dev_o       <= vidport_pkg::GRP_FF;
      bus.grp_dev_oe_n    <= 1'b1;
      map_grp_q           <= vidport_pkg::GRP_FF;
      o_standard_code_out <= '0;
      o_fifo_clear_n      <= 1'b1;
    end else if (pclk_fall) begin
      bus.flag_dev_o <= pick(grp_use, i_ff_flags, i_ap_flags,
                             i_anc_flags);
      bus.flag_dev_oe_n <= !(dir_q || o_flag_map);
      bus.grp_dev_oe_n  <= !o_flag_map;
      bus.grp_dev_o     <= map_grp_q;
      if (o_flag_map)
        map_grp_q <= (map_grp_q == vidport_pkg::GRP_ANC) ?
                     vidport_pkg::GRP_FF : map_grp_q + 2'h1;
      o_standard_code_out <= i_std_code;
      if (i_composite)
        o_fifo_clear_n <= !i_trs_id_word;
      else if (i_fifo_pulse_placement)
        o_fifo_clear_n <= !i_eav_word;
      else
        o_fifo_clear_n <= !i_sav_word;
    end
  end
  ////////////////////////////////////////////////////////////////
  // open-drain interrupt: enable low pulls the pin low
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) bus.irq_oe_n <= 1'b1;
    else          bus.irq_oe_n <= !i_edh_error;
  end
endmodule

/* File: vidport_host.sv */
// host end: wishbone-driven parallel port and flag port master
`timescale 1ns/1ps
module vidport_host (
  input  wire logic       i_clk,      // core clock
  input  wire logic       i_rst_n,    // synchronous reset, low
  input  wire logic       i_i2c_mode, // system runs i2c mode
  input  wire logic [3:0] i_wb_adr,   // wishbone word address
  input  wire logic [7:0] i_wb_dat,   // wishbone write data
  input  wire logic       i_wb_we,    // wishbone write
  input  wire logic       i_wb_sel,   // wishbone lane select
  input  wire logic       i_wb_cyc,   // wishbone cycle
  input  wire logic       i_wb_stb,   // wishbone strobe
  output logic [7:0]      o_wb_dat,   // wishbone read data
  output logic            o_wb_ack,   // wishbone acknowledge
  vidport_if.hst          bus         // pins to device
);
  logic [7:0] hb_s;  // synced bus for read data
  logic [1:0] fl_s;  // synced irq and clock out
  logic [4:0] flg_s; // synced flag port
  sync2 #(.W(15)) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_d     ({bus.hbus, bus.irq_n, bus.pclk_out, bus.flag}),
    .o_q     ({hb_s, fl_s, flg_s})
  );
  ////////////////////////////////////////////////////////////////
  // command registers
  logic [2:0] cmd_q;   // read and address flags, go pending
  logic [7:0] wdat_q, rdat_q;
  logic [7:0] flagc_q; // bit0 dir, bits2:1 group, bits7:3 override
  vidport_pkg::host_state_t st_q;
  logic [2:0] cnt_q;   // phase counter
  logic       acc;
  assign acc = i_wb_cyc && i_wb_stb && !o_wb_ack;
  // writes land only at the edge that sees ack high, request still held
  logic       wr_now;
  assign wr_now = i_wb_cyc && i_wb_stb && o_wb_ack && i_wb_we && i_wb_sel;
  // wishbone slave: one-cycle answer
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= '0;
      wdat_q   <= '0;
      flagc_q  <= 8'h01;
    end else begin
      o_wb_ack <= acc;
      if (wr_now) begin
        if (i_wb_adr == vidport_pkg::A_WDATA) wdat_q  <= i_wb_dat;
        if (i_wb_adr == vidport_pkg::A_FLAGC) flagc_q <= i_wb_dat;
      end
      case (i_wb_adr)
        vidport_pkg::A_RDATA:  o_wb_dat <= rdat_q;
        vidport_pkg::A_STATUS: o_wb_dat <= {7'h00, cmd_q[0]};
        vidport_pkg::A_FLAGC:  o_wb_dat <= flagc_q;
        vidport_pkg::A_FLAGS:  o_wb_dat <= {2'h0, fl_s[1], flg_s};
        default:               o_wb_dat <= 8'h00;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////
  // bus cycle sequencer: setup, strobe, hold
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_q  <= vidport_pkg::HS_IDLE;
      cnt_q <= '0;
      cmd_q <= '0;
      rdat_q <= '0;
    end else begin
      case (st_q)
        vidport_pkg::HS_IDLE: begin
          if (wr_now && i_wb_adr == vidport_pkg::A_CMD &&
              i_wb_dat[vidport_pkg::CMD_GO] && !i_i2c_mode) begin
            cmd_q <= {i_wb_dat[vidport_pkg::CMD_AD],
                      i_wb_dat[vidport_pkg::CMD_RD], 1'b1};
            st_q  <= vidport_pkg::HS_SETUP;
          end
        end
        vidport_pkg::HS_SETUP: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == 3'(vidport_pkg::PHASE_CYC - 1)) begin
            cnt_q <= '0;
            st_q  <= vidport_pkg::HS_STROB;
          end
        end
        vidport_pkg::HS_STROB: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == 3'(vidport_pkg::PHASE_CYC - 1)) begin
            cnt_q  <= '0;
            st_q   <= vidport_pkg::HS_HOLD;
          end
        end
        vidport_pkg::HS_HOLD: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == 3'(vidport_pkg::PHASE_CYC - 1)) begin
            cnt_q <= '0;
            cmd_q <= '0;
            // read byte taken late: device drives three clocks after
            // select, and our own bus sync adds two more
            rdat_q <= hb_s;
            st_q  <= vidport_pkg::HS_IDLE;
          end
        end
        default: st_q <= vidport_pkg::HS_IDLE;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////
  // pin drive; i2c mode holds fixed levels
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      bus.host_mode     <= 1'b0;
      bus.rd_wr         <= 1'b1;
      bus.addr_data     <= 1'b0;
      bus.port_sel_n    <= 1'b1;
      bus.hbus_hst_o    <= '0;
      bus.hbus_hst_oe_n <= 8'hff;
    end else if (i_i2c_mode) begin
      bus.host_mode     <= 1'b1;
      bus.rd_wr         <= 1'b1;
      bus.addr_data     <= 1'b0;
      bus.port_sel_n    <= 1'b1;
      bus.hbus_hst_o    <= 8'h00; // upper lines low
      bus.hbus_hst_oe_n <= 8'h1f;
    end else begin
      bus.host_mode  <= 1'b0;
      bus.rd_wr      <= cmd_q[1] && !cmd_q[2];
      bus.addr_data  <= cmd_q[2];
      bus.port_sel_n <= (st_q != vidport_pkg::HS_STROB);
      bus.hbus_hst_o <= wdat_q;
      bus.hbus_hst_oe_n <= (cmd_q[0] && !(cmd_q[1] && !cmd_q[2]))
                           ? 8'h00 : 8'hff;
    end
  end
  // flag port controls, changed on falling clock out
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      bus.flag_dir   <= 1'b1;
      bus.grp_hst_o  <= vidport_pkg::GRP_FF;
      bus.flag_hst_o <= '0;
    end else if (!fl_s[0]) begin
      bus.flag_dir   <= flagc_q[0];
      bus.grp_hst_o  <= flagc_q[2:1];
      bus.flag_hst_o <= flagc_q[7:3];
    end
  end
endmodule

/* File: vidport_if.sv */
// pin-level carrier between the video processor and its host
`timescale 1ns/1ps
interface vidport_if;
  logic [7:0] hbus_dev_o;   // device drive value
  logic [7:0] hbus_dev_oe_n;// device enable, low drives
  logic [7:0] hbus_hst_o;   // host drive value
  logic [7:0] hbus_hst_oe_n;// host enable, low drives
  logic [7:0] hbus;         // resolved host bus
  logic       rd_wr;        // high read, low write
  logic       addr_data;    // high address, low data
  logic       port_sel_n;   // port select, active low
  logic       host_mode;    // high i2c, low parallel
  logic [4:0] flag_dev_o;   // device flag drive
  logic       flag_dev_oe_n;// device flag enable
  logic [4:0] flag_hst_o;   // host flag drive
  logic       flag_dir;     // high device outputs flags
  logic [4:0] flag;         // resolved flag port
  logic [1:0] grp_dev_o;    // device group drive (flag map)
  logic       grp_dev_oe_n; // device group enable
  logic [1:0] grp_hst_o;    // host group drive
  logic [1:0] grp;          // resolved group select
  logic       irq_oe_n;     // interrupt pull-down enable
  logic       irq_n;        // resolved open-drain interrupt
  logic       pclk_out;     // parallel clock out of device
  // wire resolution from the enables
  genvar g;
  for (g = 0; g < 8; g++) begin : g_hb
    assign hbus[g] = !hbus_dev_oe_n[g] ? hbus_dev_o[g] :
                     !hbus_hst_oe_n[g] ? hbus_hst_o[g] : 1'b1;
  end
  assign flag  = !flag_dev_oe_n ? flag_dev_o :
                 !flag_dir ? flag_hst_o : 5'h1f;
  assign grp   = !grp_dev_oe_n ? grp_dev_o : grp_hst_o;
  assign irq_n = !irq_oe_n ? 1'b0 : 1'b1;
  modport dev (
    input  hbus, rd_wr, addr_data, port_sel_n, host_mode,
    input  flag, flag_dir, grp,
    output hbus_dev_o, hbus_dev_oe_n, flag_dev_o, flag_dev_oe_n,
    output grp_dev_o, grp_dev_oe_n, irq_oe_n, pclk_out
  );
  modport hst (
    input  hbus, flag, grp, irq_n, pclk_out,
    output hbus_hst_o, hbus_hst_oe_n, rd_wr, addr_data, port_sel_n,
    output host_mode, flag_hst_o, flag_dir, grp_hst_o
  );
endinterface

/* File: vidport_pkg.sv */
// shared constants and types for the video input host and flag port
package vidport_pkg;
  localparam int HBUS_W    = 8;    // host bus width
  localparam int FLAG_W    = 5;    // error flag port width
  localparam int GSEL_W    = 2;    // flag group select width
  localparam int STD_W     = 4;    // standard code width
  localparam int ADDR_W    = 3;    // slave address strap width
  localparam int SCL_BIT   = 4;    // serial clock line in i2c mode
  localparam int SDA_BIT   = 3;    // serial data line in i2c mode
  localparam int REG_NUM   = 8;    // internal register count
  localparam int REG_IDX_W = 3;    // register index width
  localparam int WB_AW     = 4;    // wishbone word address width
  localparam logic [7:0] CFG_RST = 8'h00;   // register reset value
  // flag group encodings
  localparam logic [1:0] GRP_FF  = 2'h0;
  localparam logic [1:0] GRP_AP  = 2'h1;
  localparam logic [1:0] GRP_ANC = 2'h2;
  // controller register word offsets
  localparam logic [3:0] A_CMD    = 4'h0;   // bit0 go, bit1 read, bit2 addr
  localparam logic [3:0] A_WDATA  = 4'h1;   // byte to write
  localparam logic [3:0] A_RDATA  = 4'h2;   // last byte read
  localparam logic [3:0] A_STATUS = 4'h3;   // bit0 busy
  localparam logic [3:0] A_FLAGC  = 4'h4;   // flag dir, group, override
  localparam logic [3:0] A_FLAGS  = 4'h5;   // flags seen, irq level
  localparam int CMD_GO = 0;
  localparam int CMD_RD = 1;
  localparam int CMD_AD = 2;
  // host strobe phase length in clocks
  localparam int PHASE_CYC = 4;
  // host cycle states, gray along the path
  typedef enum logic [1:0] {
    HS_IDLE  = 2'b00,
    HS_SETUP = 2'b01,
    HS_STROB = 2'b11,
    HS_HOLD  = 2'b10
  } host_state_t;
endpackage

/* File: vidport_sva.sv */
// concurrent checks on the pins between the two port ends
`timescale 1ns/1ps
module vidport_sva (
  input wire logic       i_clk,         // core clock
  input wire logic       i_rst_n,       // reset, low
  input wire logic [7:0] hbus,          // resolved host bus
  input wire logic [7:0] hbus_dev_oe_n, // device bus enables
  input wire logic [7:0] hbus_hst_oe_n, // host bus enables
  input wire logic       rd_wr,         // high read
  input wire logic       addr_data,     // high address
  input wire logic       port_sel_n,    // port select, low
  input wire logic       host_mode,     // high i2c
  input wire logic       flag_dev_oe_n, // device flag enable
  input wire logic       flag_dir,      // high device drives flags
  input wire logic       irq_n,         // open-drain interrupt
  input wire logic       pclk_out,      // parallel clock out
  input wire logic       i_edh_error    // edh error level
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////////////////////////////////
  // host bus direction, allowing for the select synchroniser
  a_float_desel: assert property (port_sel_n [*4] |-> &hbus_dev_oe_n)
    else $error("device drives bus while deselected");
  a_float_write: assert property (!rd_wr [*4] |-> &hbus_dev_oe_n)
    else $error("device drives bus in write cycle");
  a_no_contention: assert property (
    (hbus_dev_oe_n | hbus_hst_oe_n) == 8'hff)
    else $error("both ends drive the host bus");
  a_strobe_width: assert property ($fell(port_sel_n) |->
    !port_sel_n [*4] ##1 port_sel_n)
    else $error("strobe phase length wrong");
  a_i2c_pins: assert property (host_mode [*2] |->
    rd_wr && !addr_data && port_sel_n && hbus[7:5] == 3'h0)
    else $error("fixed pins wrong in i2c mode");
  ////////////////////////////////////////////////////////////////////
  // flag port direction, clock out and interrupt
  a_flag_input: assert property (!flag_dir [*4] |-> flag_dev_oe_n)
    else $error("device drives flags while they are inputs");
  a_flag_output: assert property (flag_dir [*6] |-> !flag_dev_oe_n)
    else $error("device does not drive flags");
  a_pclk_half: assert property ($past(i_rst_n) |->
    pclk_out != $past(pclk_out))
    else $error("clock out is not half rate");
  a_irq_set: assert property (i_edh_error |-> ##[1:3] !irq_n)
    else $error("interrupt not pulled low");
  a_irq_clear: assert property (!i_edh_error [*4] |-> irq_n)
    else $error("interrupt not released");
  c_read: cover property (!hbus_dev_oe_n[0]);
  c_write: cover property (!port_sel_n && !rd_wr);
  c_override: cover property (!flag_dir [*4]);
  c_irq: cover property (!irq_n);
endmodule
